// [shared/quad_mode_defines.svh]
`ifndef QUAD_MODE_DEFINES_SVH
`define QUAD_MODE_DEFINES_SVH

// instruction codes
`define OP_WRITE_STATUS 8'h01
`define OP_WRITE_DISABLE 8'h04
`define OP_READ_STATUS1 8'h05
`define OP_WRITE_ENABLE 8'h06
`define OP_READ_4B 8'h13
`define OP_READ_STATUS2 8'h35
`define OP_QPI_ENTER 8'h38
`define OP_READ_ANY_REG 8'h65
`define OP_RESET_ENABLE 8'h66
`define OP_WRITE_ANY_REG 8'h71
`define OP_RESET 8'h99
`define OP_ADDR4_ENTER 8'hB7
`define OP_QUAD_IO_READ 8'hEB
`define OP_QUAD_IO_READ_4B 8'hEC
`define OP_QPI_EXIT 8'hFF

// volatile configuration byte and its 4-4-4 enable bit
`define CFG_QPI_ADDR 32'h0080_0003
`define CFG_QPI_BIT 6
// quad enable flag position in the second status byte
`define STATUS2_QE_BIT 1
// continuous-read mode bits: upper nibble that keeps the mode
`define MODE_KEEP_NIBBLE 4'hA
// mode-bit reset: all-ones nibble held for this many serial clocks
`define MODE_RST_NIBBLE 4'hF
`define MODE_RST_CLKS 4'h8

// bit counts of the serial phases
`define BITS_BYTE 6'h08
`define BITS_ADDR3 6'h18
`define BITS_ADDR4 6'h20

`endif

// [shared/quad_mode_pkg.sv]
package quad_mode_pkg;

	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_CMD = 7'h02,
		S_ADDR = 7'h04,
		S_MODE = 7'h08,
		S_WDATA = 7'h10,
		S_RDATA = 7'h20,
		S_SKIP = 7'h40
	} phase_t;

	typedef struct packed {
		phase_t st;
		logic [7:0] opcode;
		logic [31:0] sh;
		logic [5:0] bitcnt;
		logic [7:0] out_sh;
		logic [3:0] dq_out;
		logic [3:0] dq_oe;
		logic qe;
		logic qpi;
		logic addr4;
		logic cont;
		logic cont_exit;
		logic wel;
		logic rst_en;
		logic [3:0] ffcnt;
		logic byte_idx;
		logic read_req;
		logic [31:0] addr_lat;
		logic soft_rst;
	} state_t;

endpackage : quad_mode_pkg

// [src/quad_mode_entry_exit_control.sv]
`include "quad_mode_defines.svh"

module quad_mode_entry_exit_control import quad_mode_pkg::*; (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic cs_n_in,
	input wire logic sck_in,
	input wire logic [3:0] dq_in,
	input wire logic busy_in,
	output logic [3:0] dq_out,
	output logic [3:0] dq_oe_out,
	output logic qe_out,
	output logic qpi_out,
	output logic addr4_out,
	output logic cont_read_out,
	output logic read_req_out,
	output logic [31:0] read_addr_out,
	output logic soft_reset_out
);

	state_t cur_ff;
	state_t nxt_st;
	phase_t cur;
	logic quad;
	logic is_qio;
	logic strobe;
	logic [31:0] shn;
	logic [5:0] bits_n;
	logic [5:0] addr_bits;
	logic [31:0] addr_n;
	logic cmd_done;
	logic addr_done;
	logic mode_done;
	logic wdata_done;
	logic [7:0] op_n;

	// place the leading bits of an outgoing byte on the lanes of the current width
	function automatic logic [3:0] lanes(input logic [7:0] b, input logic q);
		lanes = q ? b[7:4] : {2'h0, b[7], 1'h0};
	endfunction : lanes

	////////////////////////////////////////////////////////////////////////////////
	// phase decode: an idle phase with select low starts a frame
	assign strobe = !cs_n_in && sck_in;
	assign cur = (cur_ff.st == S_IDLE) ? (cur_ff.cont ? S_ADDR : S_CMD) : cur_ff.st;
	assign is_qio = (cur_ff.opcode == `OP_QUAD_IO_READ) || (cur_ff.opcode == `OP_QUAD_IO_READ_4B);
	// quad read address and mode always use four lanes, else the lane count follows qpi
	assign quad = cur_ff.qpi || (is_qio && (cur == S_ADDR || cur == S_MODE));
	assign shn = quad ? {cur_ff.sh[27:0], dq_in} : {cur_ff.sh[30:0], dq_in[0]};
	assign bits_n = cur_ff.bitcnt + (quad ? 6'h04 : 6'h01);
	assign op_n = shn[7:0];
	// dedicated opcodes carry four address bytes regardless of the addressing mode
	assign addr_bits = (cur_ff.addr4 || cur_ff.opcode == `OP_QUAD_IO_READ_4B ||
		cur_ff.opcode == `OP_READ_4B) ? `BITS_ADDR4 : `BITS_ADDR3;
	assign addr_n = (addr_bits == `BITS_ADDR4) ? shn : {8'h00, shn[23:0]};
	assign cmd_done = strobe && cur == S_CMD && bits_n == `BITS_BYTE;
	assign addr_done = strobe && cur == S_ADDR && bits_n == addr_bits;
	assign mode_done = strobe && cur == S_MODE && bits_n == `BITS_BYTE;
	assign wdata_done = strobe && cur == S_WDATA && bits_n == `BITS_BYTE;

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		nxt_st = cur_ff;
		nxt_st.read_req = 1'b0;
		nxt_st.soft_rst = 1'b0;
		if (cs_n_in) begin
			// frame end: a pending exit from continuous read takes effect here
			nxt_st.st = S_IDLE;
			nxt_st.bitcnt = 6'h00;
			nxt_st.byte_idx = 1'b0;
			nxt_st.ffcnt = 4'h0;
			nxt_st.dq_oe = 4'h0;
			if (cur_ff.cont_exit) begin
				nxt_st.cont = 1'b0;
				nxt_st.cont_exit = 1'b0;
			end
		end else if (sck_in) begin
			nxt_st.st = cur;
			nxt_st.sh = shn;
			nxt_st.bitcnt = bits_n;
			case (cur)
				S_CMD: begin
					if (cmd_done) begin
						nxt_st.opcode = op_n;
						nxt_st.bitcnt = 6'h00;
						nxt_st.st = S_SKIP;
						nxt_st.rst_en = (op_n == `OP_RESET_ENABLE);
						case (op_n)
							`OP_WRITE_ENABLE: nxt_st.wel = 1'b1;
							`OP_WRITE_DISABLE: nxt_st.wel = 1'b0;
							`OP_QPI_ENTER: nxt_st.qpi = 1'b1;
							`OP_QPI_EXIT: nxt_st.qpi = 1'b0;
							`OP_ADDR4_ENTER: nxt_st.addr4 = 1'b1;
							`OP_RESET: begin
								if (cur_ff.rst_en) begin
									nxt_st.qpi = 1'b0;
									nxt_st.cont = 1'b0;
									nxt_st.cont_exit = 1'b0;
									nxt_st.addr4 = 1'b0;
									nxt_st.wel = 1'b0;
									nxt_st.soft_rst = 1'b1;
								end
							end
							`OP_READ_STATUS1: begin
								nxt_st.out_sh = {6'h00, cur_ff.wel, busy_in};
								nxt_st.dq_out = lanes(nxt_st.out_sh, cur_ff.qpi);
								nxt_st.dq_oe = cur_ff.qpi ? 4'hF : 4'h2;
								nxt_st.st = S_RDATA;
							end
							`OP_READ_STATUS2: begin
								nxt_st.out_sh = 8'h00;
								nxt_st.out_sh[`STATUS2_QE_BIT] = cur_ff.qe;
								nxt_st.dq_out = lanes(nxt_st.out_sh, cur_ff.qpi);
								nxt_st.dq_oe = cur_ff.qpi ? 4'hF : 4'h2;
								nxt_st.st = S_RDATA;
							end
							`OP_WRITE_STATUS: nxt_st.st = cur_ff.wel ? S_WDATA : S_SKIP;
							`OP_WRITE_ANY_REG: nxt_st.st = cur_ff.wel ? S_ADDR : S_SKIP;
							`OP_READ_ANY_REG: nxt_st.st = S_ADDR;
							`OP_READ_4B: nxt_st.st = S_ADDR;
							// continuous quad read is only usable with the quad flag set
							`OP_QUAD_IO_READ: nxt_st.st = cur_ff.qe ? S_ADDR : S_SKIP;
							`OP_QUAD_IO_READ_4B: nxt_st.st = cur_ff.qe ? S_ADDR : S_SKIP;
							default: nxt_st.st = S_SKIP;
						endcase
					end
				end
				S_ADDR: begin
					if (addr_done) begin
						nxt_st.bitcnt = 6'h00;
						nxt_st.addr_lat = addr_n;
						case (cur_ff.opcode)
							`OP_READ_ANY_REG: begin
								nxt_st.out_sh = 8'h00;
								if (addr_n == `CFG_QPI_ADDR) begin
									nxt_st.out_sh[`CFG_QPI_BIT] = cur_ff.qpi;
								end
								nxt_st.dq_out = lanes(nxt_st.out_sh, cur_ff.qpi);
								nxt_st.dq_oe = cur_ff.qpi ? 4'hF : 4'h2;
								nxt_st.st = S_RDATA;
							end
							`OP_WRITE_ANY_REG: nxt_st.st = S_WDATA;
							`OP_READ_4B: begin
								nxt_st.read_req = 1'b1;
								nxt_st.st = S_SKIP;
							end
							default: nxt_st.st = S_MODE;
						endcase
					end
				end
				S_MODE: begin
					if (mode_done) begin
						// keep or leave continuous read; leaving waits for the frame end
						if (op_n[7:4] == `MODE_KEEP_NIBBLE) begin
							nxt_st.cont = 1'b1;
							nxt_st.cont_exit = 1'b0;
						end else begin
							nxt_st.cont_exit = 1'b1;
						end
						nxt_st.read_req = 1'b1;
						nxt_st.st = S_SKIP;
					end
				end
				S_WDATA: begin
					if (wdata_done) begin
						nxt_st.bitcnt = 6'h00;
						if (cur_ff.opcode == `OP_WRITE_STATUS) begin
							if (!cur_ff.byte_idx) begin
								nxt_st.byte_idx = 1'b1;
							end else begin
								nxt_st.qe = op_n[`STATUS2_QE_BIT];
								nxt_st.wel = 1'b0;
								nxt_st.st = S_SKIP;
							end
						end else begin
							// volatile bit: not kept over power or soft reset
							if (cur_ff.addr_lat == `CFG_QPI_ADDR) begin
								nxt_st.qpi = op_n[`CFG_QPI_BIT];
							end
							nxt_st.wel = 1'b0;
							nxt_st.st = S_SKIP;
						end
					end
				end
				S_RDATA: begin
					// a register read repeats its byte for as long as the host clocks
					nxt_st.out_sh = cur_ff.qpi ? {cur_ff.out_sh[3:0], cur_ff.out_sh[7:4]} :
						{cur_ff.out_sh[6:0], cur_ff.out_sh[7]};
					nxt_st.dq_out = lanes(nxt_st.out_sh, cur_ff.qpi);
				end
				S_SKIP: nxt_st.bitcnt = 6'h00;
				default: nxt_st.st = S_IDLE;
			endcase
			// mode-bit reset: all-ones nibbles while continuous read fetches its address and mode bits
			if (cur_ff.cont && (cur == S_ADDR || cur == S_MODE)) begin
				if (dq_in == `MODE_RST_NIBBLE) begin
					if (cur_ff.ffcnt != `MODE_RST_CLKS) begin
						nxt_st.ffcnt = cur_ff.ffcnt + 4'h1;
					end
					if (cur_ff.ffcnt + 4'h1 == `MODE_RST_CLKS) begin
						nxt_st.cont_exit = 1'b1;
					end
				end else begin
					nxt_st.ffcnt = 4'h0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register; the quad flag is nonvolatile in the array, here it resets clear
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			cur_ff <= '0;
			cur_ff.st <= S_IDLE;
		end else begin
			cur_ff <= nxt_st;
		end
	end

	assign dq_out = cur_ff.dq_out;
	assign dq_oe_out = cur_ff.dq_oe;
	assign qe_out = cur_ff.qe;
	assign qpi_out = cur_ff.qpi;
	assign addr4_out = cur_ff.addr4;
	assign cont_read_out = cur_ff.cont;
	assign read_req_out = cur_ff.read_req;
	assign read_addr_out = cur_ff.addr_lat;
	assign soft_reset_out = cur_ff.soft_rst;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence bad_mode_s;
		mode_done && op_n[7:4] != `MODE_KEEP_NIBBLE;
	endsequence
	sequence frame_end_s;
		cs_n_in;
	endsequence

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);

	qpi_enter_a: assert property (cmd_done && op_n == `OP_QPI_ENTER |=> qpi_out)
		else $error("38h did not enter quad mode");
	qpi_exit_a: assert property (cmd_done && op_n == `OP_QPI_EXIT |=> !qpi_out)
		else $error("FFh did not leave quad mode");
	soft_reset_a: assert property (cmd_done && op_n == `OP_RESET && cur_ff.rst_en
		|=> !qpi_out && soft_reset_out ##1 !soft_reset_out)
		else $error("soft reset did not leave quad mode");
	addr4_enter_a: assert property (cmd_done && op_n == `OP_ADDR4_ENTER |=> addr4_out)
		else $error("B7h did not select 4-byte addressing");
	qe_write_a: assert property (wdata_done && cur_ff.opcode == `OP_WRITE_STATUS &&
		cur_ff.byte_idx |=> qe_out == $past(shn[`STATUS2_QE_BIT]))
		else $error("quad flag not taken from second byte");
	cont_enter_a: assert property (mode_done && op_n[7:4] == `MODE_KEEP_NIBBLE
		|=> cont_read_out && read_req_out)
		else $error("mode nibble A did not hold continuous read");
	// the mode byte and the all-ones count only arm the exit; the host never deselects
	// on the cycle right after a strobe, so the exit itself is checked at the frame end
	cont_leave_a: assert property (bad_mode_s |=> cur_ff.cont_exit)
		else $error("non-A mode bits did not arm the exit");
	mode_reset_a: assert property (strobe && cur_ff.cont && (cur == S_ADDR || cur == S_MODE)
		&& cur_ff.ffcnt == 4'h7 && dq_in == 4'hF |=> cur_ff.cont_exit)
		else $error("mode-bit reset ignored");
	exit_at_end_a: assert property (frame_end_s ##0 cur_ff.cont_exit
		|=> !cont_read_out && !cur_ff.cont_exit)
		else $error("continuous read not left at frame end");
	// a quad read with the flag clear must be skipped to the frame end
	qio_refused_a: assert property (cmd_done && op_n == `OP_QUAD_IO_READ && !cur_ff.qe
		|=> cur_ff.st == S_SKIP)
		else $error("quad read accepted with quad flag clear");
	oe_release_a: assert property (frame_end_s |=> dq_oe_out == 4'h0)
		else $error("lanes still driven after deselect");
	cfg_write_a: assert property (wdata_done && cur_ff.opcode == `OP_WRITE_ANY_REG &&
		cur_ff.addr_lat == `CFG_QPI_ADDR |=> qpi_out == $past(shn[`CFG_QPI_BIT]))
		else $error("config bit 6 did not steer quad mode");
	mode_slot_a: assert property (addr_done && is_qio |=> cur_ff.st == S_MODE
		##0 cur_ff.bitcnt == 6'h00)
		else $error("mode bits not right after address");
	status2_a: assert property (cmd_done && op_n == `OP_READ_STATUS2
		|=> dq_oe_out != 4'h0 && cur_ff.out_sh[`STATUS2_QE_BIT] == qe_out)
		else $error("status byte two does not show quad flag");

endmodule : quad_mode_entry_exit_control

// [verification/quad_host_model.sv]
// host side of the serial link: frames, strobes and lane reads
module quad_host_model (
	input wire logic mclk_in,
	input wire logic [3:0] dq_in,
	output logic cs_n_out,
	output logic sck_out,
	output logic [3:0] dq_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle: deselected, no strobe
	initial begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
		dq_out = 4'h0;
	end

	// one strobe; lanes flip afterwards so no stale level is mistaken for data
	task automatic strobe(input logic [3:0] d);
		@(negedge mclk_in);
		sck_out = 1'b1;
		dq_out = d;
		@(negedge mclk_in);
		sck_out = 1'b0;
		dq_out = ~d;
	endtask : strobe

	task automatic start();
		@(negedge mclk_in);
		cs_n_out = 1'b0;
	endtask : start

	// two idle cycles after deselect let frame-end effects land
	task automatic stop();
		@(negedge mclk_in);
		cs_n_out = 1'b1;
		@(negedge mclk_in);
		@(negedge mclk_in);
	endtask : stop

	// n whole units msb first, nibbles on four lanes or bits on lane 0
	task automatic send(input logic [31:0] v, input int n, input logic q);
		for (int i = n - 1; i >= 0; i--) begin
			if (q) begin
				strobe(v[4*i +: 4]);
			end else begin
				strobe({{3{~v[i]}}, v[i]});
			end
		end
	endtask : send

	// single-lane read on lane 1, one bit ahead of each strobe
	task automatic recv(input int n, output logic [7:0] r);
		r = 8'h00;
		for (int i = 0; i < n; i++) begin
			r = {r[6:0], dq_in[1]};
			strobe(4'h5);
		end
	endtask : recv
endmodule : quad_host_model

// [verification/quad_mode_entry_exit_control_tb.sv]
`include "quad_mode_defines.svh"

module quad_mode_entry_exit_control_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic busy_in = 1'b0;
	logic cs_n, sck, qe, qpi, addr4, cont, rreq, srst;
	logic [3:0] host_dq, dev_dq, dev_oe, dq_bus;
	logic [31:0] raddr;
	logic [7:0] rb;
	int num_errors = 0;
	int checked = 0;

	always #4 mclk_in = ~mclk_in;

	// wire level: each lane follows whoever drives it
	assign dq_bus = (dev_oe & dev_dq) | (~dev_oe & host_dq);

	quad_host_model host (.mclk_in(mclk_in), .dq_in(dq_bus), .cs_n_out(cs_n),
		.sck_out(sck), .dq_out(host_dq));

	quad_mode_entry_exit_control dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.cs_n_in(cs_n), .sck_in(sck), .dq_in(dq_bus), .busy_in(busy_in),
		.dq_out(dev_dq), .dq_oe_out(dev_oe), .qe_out(qe), .qpi_out(qpi),
		.addr4_out(addr4), .cont_read_out(cont), .read_req_out(rreq),
		.read_addr_out(raddr), .soft_reset_out(srst));

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic give_verdict();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict

	task automatic cmd(input logic [7:0] op, input logic q);
		host.start();
		host.send(op, q ? 2 : 8, q);
	endtask : cmd

	// one read with mode byte m, in a fresh frame or a continuous one
	task automatic qread(input logic fresh, input logic [23:0] a, input logic [7:0] m);
		if (fresh) cmd(`OP_QUAD_IO_READ, 1'b0);
		else host.start();
		host.send(a, 6, 1'b1);
		host.send(m, 2, 1'b1);
		check("read_req", rreq, 1);
		check("read_addr", raddr, a);
		host.stop();
	endtask : qread

	////////////////////////////////////////////////////////////////////////////
	// hang guard: a run this long counts as a failure
	initial begin
		repeat (30000) @(posedge mclk_in);
		num_errors++;
		give_verdict();
	end

	// main sequence
	initial begin
		repeat (5) @(negedge mclk_in);
		rst_n_in = 1'b1;
		check("flags", {qe, qpi, addr4, cont}, 4'h0);
		busy_in = 1'b1;
		cmd(`OP_READ_STATUS1, 1'b0);
		check("oe", dev_oe, 4'h2);
		host.recv(8, rb);
		host.stop();
		check("status1", rb, 8'h01);
		check("oe_idle", dev_oe, 4'h0);
		// status write without enable is refused
		cmd(`OP_WRITE_STATUS, 1'b0);
		host.send(16'h0002, 16, 1'b0);
		host.stop();
		check("qe", qe, 1'b0);
		// quad read with the flag still clear is ignored
		cmd(`OP_QUAD_IO_READ, 1'b0);
		host.send(32'h1234_56A5, 8, 1'b1);
		check("refused_read", {rreq, cont}, 2'b00);
		host.stop();
		cmd(`OP_WRITE_ENABLE, 1'b0);
		host.stop();
		cmd(`OP_WRITE_STATUS, 1'b0);
		host.send(16'h0002, 16, 1'b0);
		host.stop();
		check("qe", qe, 1'b1);
		cmd(`OP_READ_STATUS2, 1'b0);
		host.recv(8, rb);
		host.stop();
		check("status2", rb, 8'h02);
		// dedicated four-byte read while three-byte mode is selected
		cmd(`OP_QUAD_IO_READ_4B, 1'b0);
		host.send(32'h89AB_CDEF, 8, 1'b1);
		host.send(8'h00, 2, 1'b1);
		check("addr_4b", raddr, 32'h89AB_CDEF);
		host.stop();
		qread(1'b1, 24'h12_3456, 8'hA5);
		check("cont", cont, 1'b1);
		qread(1'b0, 24'h11_1111, 8'hA3);
		check("cont", cont, 1'b1);
		qread(1'b0, 24'h22_2222, 8'h5A);
		check("cont", cont, 1'b0);
		qread(1'b1, 24'h12_3456, 8'hA5);
		qread(1'b0, 24'h33_3333, 8'h00);
		check("cont", cont, 1'b0);
		qread(1'b1, 24'h12_3456, 8'hA5);
		host.start();
		host.send(32'hFFFF_FFFF, 8, 1'b1);
		host.stop();
		check("cont", cont, 1'b0);
		// all-quad mode through the volatile configuration byte
		cmd(`OP_WRITE_ENABLE, 1'b0);
		host.stop();
		cmd(`OP_WRITE_ANY_REG, 1'b0);
		host.send(`CFG_QPI_ADDR, 24, 1'b0);
		host.send(8'h40, 8, 1'b0);
		host.stop();
		check("qpi", qpi, 1'b1);
		// read back the volatile byte on four lanes: upper nibble carries bit 6
		cmd(`OP_READ_ANY_REG, 1'b1);
		host.send(`CFG_QPI_ADDR, 6, 1'b1);
		check("cfg_read", {dev_oe, dev_dq}, 8'hF4);
		host.stop();
		cmd(`OP_WRITE_ENABLE, 1'b1);
		host.stop();
		cmd(`OP_WRITE_ANY_REG, 1'b1);
		host.send(`CFG_QPI_ADDR, 6, 1'b1);
		host.send(8'h00, 2, 1'b1);
		host.stop();
		check("qpi", qpi, 1'b0);
		cmd(`OP_ADDR4_ENTER, 1'b0);
		host.stop();
		check("addr4", addr4, 1'b1);
		cmd(`OP_QPI_ENTER, 1'b0);
		host.stop();
		check("qpi", qpi, 1'b1);
		cmd(`OP_QPI_EXIT, 1'b1);
		host.stop();
		check("qpi", qpi, 1'b0);
		// reset without its enable does nothing
		cmd(`OP_RESET, 1'b0);
		check("soft_reset", srst, 1'b0);
		host.stop();
		cmd(`OP_QPI_ENTER, 1'b0);
		host.stop();
		cmd(`OP_RESET_ENABLE, 1'b1);
		host.stop();
		cmd(`OP_RESET, 1'b1);
		check("soft_reset", srst, 1'b1);
		host.stop();
		check("qpi_addr4", {qpi, addr4}, 2'b00);
		give_verdict();
	end
endmodule : quad_mode_entry_exit_control_tb
